// File: bench/sfp_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module sfp_mem_model (
  input wire logic clk,
  input wire logic ic_req,
  input wire logic [31:0] ic_addr,
  output logic ic_ack,
  output logic [31:0] ic_data,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [3:0] ack_wait,
  input wire logic [3:0] wr_wait
);
  logic [15:0] prog [0:63];
  logic [3:0] ic_cnt = 4'h0;
  logic [3:0] wr_cnt = 4'h0;
  initial
  begin
    ic_ack = 1'b0;
    ic_data = 32'h0;
    wr_ready = 1'b0;
  end
  // ----------------------------------------
  // fetch side
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (ic_req && ic_cnt >= ack_wait)
    begin
      ic_ack <= 1'b1;
      ic_data <= {prog[ic_addr[7:2]], 16'h0000};
      ic_cnt <= 4'h0;
    end
    else
    begin
      ic_ack <= 1'b0;
      // outside answers the word is inverted every cycle, so the stale word returns every second cycle
      ic_data <= ~ic_data;
      ic_cnt <= ic_req ? ic_cnt + 4'h1 : 4'h0;
    end
  end
  // ----------------------------------------
  // write side
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (wr_valid && !wr_ready && wr_cnt >= wr_wait)
    begin
      wr_ready <= 1'b1;
      wr_cnt <= 4'h0;
    end
    else
    begin
      wr_ready <= 1'b0;
      wr_cnt <= wr_valid ? wr_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // sfp_mem_model
`default_nettype wire

// File: bench/superscalar_fetch_issue_pipeline_tb.sv
`timescale 1ns/1ns
`default_nettype none
module superscalar_fetch_issue_pipeline_tb;
  logic clk, nrst, ss, fe, bc_en, bc_v, ic_req, ic_ack, redir, fpu_v, emu, wv, wr_rdy;
  logic [1:0] bc_idx, ret;
  logic [31:0] bc_tag, bc_tgt, ic_addr, ic_data, emu_a, wa, wd;
  logic [15:0] fpu_op;
  logic [3:0] ack_w, wr_w;
  logic [31:0] fq[$];
  logic [31:0] fop, eadr, wra, wrd, pa;
  logic pend;
  int n_fpu, n_emu, n_red, n_p1, n_ret, n_wr, err_count, n_compared;
  sfp_fetch_issue dut (.REF_CLK(clk), .NRST(nrst), .SUPERSCALAR_EN(ss), .FPU_EN(fe),
    .BC_WR_EN(bc_en), .BC_WR_IDX(bc_idx), .BC_WR_VALID(bc_v), .BC_WR_TAG(bc_tag),
    .BC_WR_TARGET(bc_tgt), .IC_REQ(ic_req), .IC_ADDR(ic_addr), .IC_ACK(ic_ack),
    .IC_DATA(ic_data), .REDIRECT(redir), .FPU_VALID(fpu_v), .FPU_OP(fpu_op),
    .EMU_TRAP(emu), .EMU_ADDR(emu_a), .MEM_WR_VALID(wv), .MEM_WR_ADDR(wa),
    .MEM_WR_DATA(wd), .MEM_WR_READY(wr_rdy), .RETIRE(ret));
  sfp_mem_model mem (.clk(clk), .ic_req(ic_req), .ic_addr(ic_addr), .ic_ack(ic_ack),
    .ic_data(ic_data), .wr_valid(wv), .wr_ready(wr_rdy), .ack_wait(ack_w), .wr_wait(wr_w));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // monitor
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (ic_req && ic_ack) fq.push_back(ic_addr);
    if (fpu_v === 1'b1) begin n_fpu++; fop = {16'h0000, fpu_op}; end
    if (emu === 1'b1) begin n_emu++; eadr = emu_a; end
    if (redir === 1'b1) n_red++;
    n_p1 += int'(ret[1] === 1'b1);
    n_ret += int'(ret[0] === 1'b1) + int'(ret[1] === 1'b1);
    if (wv && wr_rdy) begin n_wr++; wra = wa; wrd = wd; end
    if (pend) chk({31'h0, wv}, 32'h1, "wr held");
    if (pend) chk(wa, pa, "wr addr");
    pend = wv && !wr_rdy;
    pa = wa;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  function automatic logic [31:0] seen(input logic [31:0] a);
    seen = 32'h0;
    foreach (fq[i]) if (fq[i] === a) seen = 32'h1;
  endfunction
  task automatic rst(input logic s, input logic f, input logic [3:0] aw, input logic [3:0] ww);
    @(negedge clk);
    nrst = 1'b0;
    ss = s;
    fe = f;
    ack_w = aw;
    wr_w = ww;
    for (int i = 0; i < 64; i++) mem.prog[i] = 16'h1000;
    repeat (4) @(negedge clk);
    fq.delete();
    {n_fpu, n_emu, n_red, n_p1, n_ret, n_wr, pend} = '0;
    nrst = 1'b1;
  endtask
  task automatic bc_wr(input logic [1:0] i, input logic v, input logic [31:0] t, g);
    @(negedge clk);
    {bc_en, bc_idx, bc_v, bc_tag, bc_tgt} = {1'b1, i, v, t, g};
    @(negedge clk);
    bc_en = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_branch;
    rst(1'b1, 1'b1, 4'h0, 4'h0);
    bc_wr(2'h0, 1'b0, 32'h20, 32'h40);
    bc_wr(2'h1, 1'b1, 32'h30, 32'h80);
    repeat (30) @(negedge clk);
    chk(fq[0], 32'h0, "first");
    chk(fq[3], 32'hC, "fourth");
    chk(32'(fq.size() > 12), 32'h1, "fetches");
    chk(seen(32'h24), 32'h1, "invalid entry");
    chk(seen(32'h34), 32'h0, "dropped");
    chk(seen(32'h80), 32'h1, "target");
    chk(32'(n_red), 32'h1, "redirects");
    $display("branch test done");
  endtask
  task automatic t_store(input logic s);
    rst(s, 1'b1, 4'h0, 4'h6);
    mem.prog[0] = 16'h3010;
    mem.prog[4] = 16'hF123;
    repeat (40) @(negedge clk);
    chk(32'(n_wr), 32'h1, "writes");
    chk(wra, 32'h10, "wr addr");
    chk(wrd, 32'h3010, "wr data");
    chk(32'(n_fpu), 32'h1, "fp kept in pipe 0");
    chk(32'(n_p1 > 0), {31'h0, s}, "pipe1");
    chk(32'(n_ret > 10), 32'h1, "retired");
    $display("store test done");
  endtask
  task automatic t_fp(input logic f, input logic [15:0] op, input logic [31:0] ne);
    rst(1'b0, f, 4'h2, 4'h0);
    mem.prog[2] = op;
    repeat (40) @(negedge clk);
    chk(32'(n_fpu), 32'h1 - ne, "fpu count");
    chk(32'(n_emu), ne, "trap count");
    if (ne == 0) chk(fop, {16'h0000, op}, "fpu op");
    else chk(eadr, 32'h8, "trap addr");
    chk(32'(n_p1), 32'h0, "pipe1 off");
    $display("fp test done");
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    {nrst, ss, fe, bc_en, bc_v, bc_idx, bc_tag, bc_tgt, ack_w, wr_w} = '0;
    {err_count, n_compared, pend} = '0;
    t_branch();
    t_store(1'b1);
    t_store(1'b0);
    t_fp(1'b1, 16'hF123, 32'h0);
    t_fp(1'b0, 16'hF123, 32'h1);
    t_fp(1'b1, 16'hA000, 32'h1);
    end_of_test();
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule // superscalar_fetch_issue_pipeline_tb
`default_nettype wire

// File: src/sfp_fetch_issue.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RULE1 - instructions pass address, fetch, early decode, buffer stages in order
// RULE2 - early decode turns each fetched word into a fixed internal format
// RULE3 - buffer keeps decoded entries until an integer pipe takes them
// RULE4 - every generated fetch address is looked up in the branch cache
// RULE5 - branch cache miss keeps fetching at sequential addresses
// RULE6 - branch cache hit drops the sequential stream and fetches at target
// RULE7 - issue takes a pair every cycle unless buffer empty or pipes held; code takes one when under two entries or second is store/fp/trap
// RULE8 - each integer pipe has six ordered stages
// RULE9 - floating-point work goes to the FPU after operand fetch
// RULE10 - write-back holds store data until memory accepts it
// RULE11 - superscalar disable turns off the second integer pipe
// RULE12 - most integer instructions spend one cycle in execution
// RULE13 - rare integer instructions trap to software emulation
// RULE14 - FPU runs beside integer pipes and can be disabled
// RULE15 - with superscalar off, at most one issue per cycle, to pipe 0
module sfp_fetch_issue
  import sfp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic SUPERSCALAR_EN,
  input wire logic FPU_EN,
  input wire logic BC_WR_EN,
  input wire logic [BC_AW-1:0] BC_WR_IDX,
  input wire logic BC_WR_VALID,
  input wire logic [31:0] BC_WR_TAG,
  input wire logic [31:0] BC_WR_TARGET,
  output logic IC_REQ,
  output logic [31:0] IC_ADDR,
  input wire logic IC_ACK,
  input wire logic [31:0] IC_DATA,
  output logic REDIRECT,
  output logic FPU_VALID,
  output logic [15:0] FPU_OP,
  output logic EMU_TRAP,
  output logic [31:0] EMU_ADDR,
  output logic MEM_WR_VALID,
  output logic [31:0] MEM_WR_ADDR,
  output logic [31:0] MEM_WR_DATA,
  input wire logic MEM_WR_READY,
  output logic [1:0] RETIRE
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic ia_vld;
  logic [31:0] ia_addr;
  logic if_vld;
  logic if_got;
  logic [31:0] if_addr;
  logic [31:0] if_data;
  logic ed_vld;
  logic [31:0] ed_addr;
  logic [31:0] ed_data;
  logic [FMT_W-1:0] ib_mem [IB_DEPTH];
  logic [IB_AW-1:0] ib_head;
  logic [IB_AW-1:0] ib_tail;
  logic [IB_AW:0] ib_cnt;
  logic bc_vld [BC_ENTRIES];
  logic [31:0] bc_tag [BC_ENTRIES];
  logic [31:0] bc_tgt [BC_ENTRIES];
  logic pv [NUM_PIPES][PIPE_STAGES];
  logic [FMT_W-1:0] pi [NUM_PIPES][PIPE_STAGES];
  logic bc_hit;
  logic [31:0] bc_target;
  logic ed_free;
  logic if_move;
  logic if_free;
  logic ia_move;
  logic ib_push;
  logic [FMT_W-1:0] ed_fmt;
  logic hold;
  logic take0;
  logic take1;
  logic [FMT_W-1:0] ib_first;
  logic [FMT_W-1:0] ib_second;
  logic wb_store_in;

  // ----------------------------------------
  // fetch stage handshakes
  // ----------------------------------------
  assign ed_free = !ed_vld || (ib_cnt < (IB_AW+1)'(IB_DEPTH));
  assign if_move = if_vld && if_got && ed_free;
  assign if_free = !if_vld || if_move;
  assign ia_move = ia_vld && if_free;
  assign ib_push = ed_vld && ed_free;

  // RULE4 branch cache lookup
  always_comb
  begin
    bc_hit = 1'b0;
    bc_target = 32'h0000_0000;
    for (int i = 0; i < BC_ENTRIES; i++)
    begin
      if (bc_vld[i] && (bc_tag[i] == ia_addr) && !bc_hit)
      begin
        bc_hit = 1'b1;
        bc_target = bc_tgt[i];
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    for (int i = 0; i < BC_ENTRIES; i++)
    begin
      if (!NRST)
        bc_vld[i] <= 1'b0;
      else if (BC_WR_EN && (BC_WR_IDX == BC_AW'(i)))
      begin
        bc_vld[i] <= BC_WR_VALID;
        bc_tag[i] <= BC_WR_TAG;
        bc_tgt[i] <= BC_WR_TARGET;
      end
    end
  end

  // ----------------------------------------
  // stage 1: fetch address
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      ia_vld <= 1'b0;
      ia_addr <= RESET_PC;
      REDIRECT <= 1'b0;
    end
    else
    begin
      ia_vld <= 1'b1;
      REDIRECT <= ia_move && bc_hit;
      // RULE6 redirect on hit
      if (ia_move && bc_hit)
        ia_addr <= bc_target;
      // RULE5 sequential on miss
      else if (ia_move)
        ia_addr <= ia_addr + FETCH_STEP;
    end
  end

  // ----------------------------------------
  // stage 2: fetch from memory
  // ----------------------------------------
  // RULE1 address to fetch stage
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      if_vld <= 1'b0;
      if_got <= 1'b0;
      if_addr <= RESET_PC;
      if_data <= 32'h0000_0000;
    end
    else if (ia_move)
    begin
      if_vld <= 1'b1;
      if_got <= 1'b0;
      if_addr <= ia_addr;
    end
    else if (if_move)
      if_vld <= 1'b0;
    else if (if_vld && !if_got && IC_ACK)
    begin
      if_got <= 1'b1;
      if_data <= IC_DATA;
    end
  end

  // request held until acknowledged; data parked so the cache never stalls
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      IC_REQ <= 1'b0;
      IC_ADDR <= RESET_PC;
    end
    else if (ia_move)
    begin
      IC_REQ <= 1'b1;
      IC_ADDR <= ia_addr;
    end
    else if (IC_ACK)
      IC_REQ <= 1'b0;
  end

  // ----------------------------------------
  // stage 3: early decode
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      ed_vld <= 1'b0;
      ed_addr <= RESET_PC;
      ed_data <= 32'h0000_0000;
    end
    else if (if_move)
    begin
      ed_vld <= 1'b1;
      ed_addr <= if_addr;
      ed_data <= if_data;
    end
    else if (ib_push)
      ed_vld <= 1'b0;
  end

  // RULE2 fixed-length format
  always_comb
  begin
    ed_fmt = '0;
    ed_fmt[FMT_OP_LSB +: 16] = ed_data[31:16];
    ed_fmt[FMT_FP] = ed_data[31:28] == FP_LINE;
    ed_fmt[FMT_STORE] = ed_data[31:28] == STORE_LINE;
    ed_fmt[FMT_MEM] = (ed_data[21:19] != 3'h0) || (ed_data[31:28] == STORE_LINE);
    // RULE13 flag emulated opwords
    ed_fmt[FMT_EMU] = ed_data[31:28] == EMU_LINE;
    ed_fmt[FMT_ADDR_LSB +: 32] = ed_addr;
  end

  // ----------------------------------------
  // stage 4: instruction buffer
  // ----------------------------------------
  assign hold = MEM_WR_VALID && !MEM_WR_READY;
  assign ib_first = ib_mem[ib_head];
  assign ib_second = ib_mem[ib_head + IB_AW'(1)];
  // RULE7 pair every cycle
  assign take0 = !hold && (ib_cnt != '0);
  // RULE11 second pipe gated
  // RULE15 single issue when scalar
  // RULE9 fp kept in pipe 0
  // only pipe 0 owns write port, FPU hand-off and trap, so those never issue as the second of a pair
  assign take1 = take0 && SUPERSCALAR_EN && (ib_cnt >= (IB_AW+1)'(2))
                 && !ib_second[FMT_STORE] && !ib_second[FMT_FP] && !ib_second[FMT_EMU];

  // RULE3 buffer retains entries
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      ib_head <= '0;
      ib_tail <= '0;
      ib_cnt <= '0;
    end
    else
    begin
      if (ib_push)
      begin
        ib_mem[ib_tail] <= ed_fmt;
        ib_tail <= ib_tail + IB_AW'(1);
      end
      ib_head <= ib_head + IB_AW'(take0) + IB_AW'(take1);
      ib_cnt <= ib_cnt + (IB_AW+1)'(ib_push) - (IB_AW+1)'(take0) - (IB_AW+1)'(take1);
    end
  end

  // ----------------------------------------
  // dual integer pipes
  // ----------------------------------------
  // RULE8 six ordered stages
  // RULE12 one cycle per stage
  always_ff @(posedge REF_CLK)
  begin
    for (int p = 0; p < NUM_PIPES; p++)
    begin
      if (!NRST)
      begin
        for (int s = 0; s < PIPE_STAGES; s++)
          pv[p][s] <= 1'b0;
      end
      else if (!hold)
      begin
        for (int s = PIPE_STAGES - 1; s > 0; s--)
        begin
          pv[p][s] <= pv[p][s-1];
          pi[p][s] <= pi[p][s-1];
        end
        pv[p][ST_DEC] <= (p == 0) ? take0 : take1;
        pi[p][ST_DEC] <= (p == 0) ? ib_first : ib_second;
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      RETIRE <= 2'h0;
    else
      RETIRE <= {pv[1][ST_WB] && !hold, pv[0][ST_WB] && !hold};
  end

  // ----------------------------------------
  // FPU hand-off and emulation trap
  // ----------------------------------------
  // RULE9 FPU after operand fetch
  // RULE14 FPU disable
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      FPU_VALID <= 1'b0;
      FPU_OP <= 16'h0000;
      EMU_TRAP <= 1'b0;
      EMU_ADDR <= 32'h0000_0000;
    end
    else
    begin
      FPU_VALID <= 1'b0;
      EMU_TRAP <= 1'b0;
      if (!hold && pv[0][ST_OPF] && pi[0][ST_OPF][FMT_FP] && FPU_EN)
      begin
        FPU_VALID <= 1'b1;
        FPU_OP <= pi[0][ST_OPF][FMT_OP_LSB +: 16];
      end
      // RULE13 trap to software
      // a disabled FPU leaves fp opwords to the same emulation path
      if (!hold && pv[0][ST_OPF] && (pi[0][ST_OPF][FMT_EMU]
          || (pi[0][ST_OPF][FMT_FP] && !FPU_EN)))
      begin
        EMU_TRAP <= 1'b1;
        EMU_ADDR <= pi[0][ST_OPF][FMT_ADDR_LSB +: 32];
      end
    end
  end

  // ----------------------------------------
  // write-back to memory side
  // ----------------------------------------
  assign wb_store_in = !hold && pv[0][ST_AVL] && pi[0][ST_AVL][FMT_STORE];

  // RULE10 hold until accepted
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      MEM_WR_VALID <= 1'b0;
      MEM_WR_ADDR <= 32'h0000_0000;
      MEM_WR_DATA <= 32'h0000_0000;
    end
    else if (wb_store_in)
    begin
      MEM_WR_VALID <= 1'b1;
      MEM_WR_ADDR <= pi[0][ST_AVL][FMT_ADDR_LSB +: 32]
                     + {24'h00_0000, pi[0][ST_AVL][7:0]};
      MEM_WR_DATA <= {16'h0000, pi[0][ST_AVL][FMT_OP_LSB +: 16]};
    end
    else if (MEM_WR_READY)
      MEM_WR_VALID <= 1'b0;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  AST_FETCH_ORDER: assert property (if_move |=> ed_vld) // RULE1
    else $error("fetched word did not reach early decode");
  AST_DECODE_FMT: assert property ( // RULE2
    ib_push && (ed_data[31:28] == FP_LINE) |=> ib_mem[$past(ib_tail)][FMT_FP])
    else $error("fp class lost in fixed format");
  AST_BUF_RETAIN: assert property ( // RULE3
    (ib_cnt == (IB_AW+1)'(IB_DEPTH)) && !take0 |=> ib_cnt == (IB_AW+1)'(IB_DEPTH))
    else $error("buffer dropped an entry");
  AST_SEQ_FETCH: assert property ( // RULE5
    ia_move && !bc_hit |=> ia_addr == $past(ia_addr) + FETCH_STEP)
    else $error("miss did not advance sequentially");
  AST_REDIRECT: assert property ( // RULE6
    ia_move && bc_hit |=> (ia_addr == $past(bc_target)) && REDIRECT)
    else $error("hit did not redirect fetch");
  AST_ISSUE: assert property ((ib_cnt != '0) && !hold |=> pv[0][ST_DEC]) // RULE7
    else $error("issue stalled without cause");
  AST_SIX_STAGE: assert property (take0 ##1 !hold [*5] |=> pv[0][ST_WB]) // RULE8
    else $error("pipe 0 not six stages deep");
  AST_FPU_PASS: assert property ( // RULE9
    !hold && pv[0][ST_OPF] && pi[0][ST_OPF][FMT_FP] && FPU_EN |=> FPU_VALID)
    else $error("fp op not handed to FPU");
  AST_PIPE1_CLASS: assert property ( // RULE9
    pv[1][ST_DEC] |-> !(pi[1][ST_DEC][FMT_FP] || pi[1][ST_DEC][FMT_EMU]
    || pi[1][ST_DEC][FMT_STORE]))
    else $error("pipe 1 holds fp, trap or store work");
  AST_WB_HOLD: assert property ( // RULE10
    MEM_WR_VALID && !MEM_WR_READY
    |=> MEM_WR_VALID && $stable(MEM_WR_ADDR) && $stable(MEM_WR_DATA))
    else $error("store released before acceptance");
  AST_SCALAR: assert property (!SUPERSCALAR_EN && !hold |=> !pv[1][ST_DEC]) // RULE11
    else $error("pipe 1 loaded while scalar");
  AST_EMU_TRAP: assert property ( // RULE13
    !hold && pv[0][ST_OPF] && pi[0][ST_OPF][FMT_EMU] |=> EMU_TRAP)
    else $error("emulated op did not trap");
  AST_FPU_OFF: assert property (!FPU_EN |=> !FPU_VALID) // RULE14
    else $error("disabled FPU received work");

  COV_HIT: cover property (ia_move && bc_hit);
  COV_PAIR: cover property (take0 && take1);
  COV_WB_STALL: cover property (hold [*3] ##1 !hold);
  COV_FPU: cover property (FPU_VALID);
endmodule // sfp_fetch_issue
`default_nettype wire

// File: src/sfp_pkg.sv
`default_nettype none
package sfp_pkg;
  // ----------------------------------------
  // pipeline geometry
  // ----------------------------------------
  localparam int FETCH_STAGES = 4;
  localparam int PIPE_STAGES = 6;
  localparam int NUM_PIPES = 2;
  localparam int IB_DEPTH = 4;
  localparam int IB_AW = 2;
  localparam int BC_ENTRIES = 4;
  localparam int BC_AW = 2;
  // integer stage indices
  localparam int ST_DEC = 0;
  localparam int ST_AGEN = 1;
  localparam int ST_OPF = 2;
  localparam int ST_EXE = 3;
  localparam int ST_AVL = 4;
  localparam int ST_WB = 5;
  // ----------------------------------------
  // addresses and reset values
  // ----------------------------------------
  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [31:0] FETCH_STEP = 32'h0000_0004;
  // ----------------------------------------
  // opword classes
  // ----------------------------------------
  localparam logic [3:0] FP_LINE = 4'hF;
  localparam logic [3:0] EMU_LINE = 4'hA;
  localparam logic [3:0] STORE_LINE = 4'h3;
  // ----------------------------------------
  // fixed-length internal format
  // ----------------------------------------
  localparam int FMT_OP_LSB = 0;
  localparam int FMT_FP = 16;
  localparam int FMT_MEM = 17;
  localparam int FMT_STORE = 18;
  localparam int FMT_EMU = 19;
  localparam int FMT_ADDR_LSB = 20;
  localparam int FMT_W = 52;
endpackage
`default_nettype wire
